// ===== rtl/spg_pkg.sv
// Package for the stop-mode power gating block: register map, field
// positions, reset values, mode and power-level types, and the state record.
// Assumes an 8-bit register port with a 4-bit address.
package spg_pkg;

    // Register port widths
    localparam int AW = 4;
    localparam int DW = 8;

    // Register offsets
    localparam logic [3:0] ADDR_MODE_CFG = 4'h0;
    localparam logic [3:0] ADDR_CLK_CFG  = 4'h1;
    localparam logic [3:0] ADDR_AUX_CFG  = 4'h2;
    localparam logic [3:0] ADDR_STATUS   = 4'h3;

    // Mode configuration fields
    localparam int B_LVD_EN      = 0;
    localparam int B_LVD_STOP_EN = 1;
    localparam int B_DEEP_SEL    = 2;
    localparam int B_DEBUG_EN    = 3;
    localparam int B_STOP_EN     = 4;

    // Clock configuration fields
    localparam int B_IREF_CLK_EN  = 0;
    localparam int B_IREF_STOP_EN = 1;
    localparam int B_EREF_CLK_EN  = 2;
    localparam int B_EREF_STOP_EN = 3;
    localparam int B_CRYSTAL_OSCILLATOR_RANGE   = 4;
    localparam int B_ADC_ASYNC    = 5;
    localparam int B_CMP_BANDGAP  = 6;

    // Auxiliary configuration fields
    localparam int B_PS_LO     = 0;
    localparam int B_PS_HI     = 3;
    localparam int B_USB_EN    = 4;
    localparam int B_USB_PHYEN = 5;

    // Status fields
    localparam int B_ST_MODE_LO = 0;
    localparam int B_ST_MODE_HI = 1;
    localparam int B_ST_REG_ON  = 2;
    localparam int B_ST_DBG_CLK = 3;

    // Values after reset
    localparam logic [7:0] RST_CFG  = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [3:0] PS_OFF   = 4'h0;

    // Operating depth
    typedef enum logic [1:0] {SPG_RUN, SPG_LIGHT, SPG_DEEP} spg_mode_e;

    // Power level of one domain
    typedef enum logic [1:0] {PWR_OFF, PWR_STBY, PWR_ON} spg_pwr_e;

    // Whole register state of the top module
    typedef struct packed {
        spg_mode_e  mode;
        logic [7:0] mode_cfg;
        logic [7:0] clk_cfg;
        logic [7:0] aux_cfg;
        logic [7:0] snap_mode;
        logic [7:0] snap_clk;
        logic [7:0] snap_aux;
        logic [7:0] rdata;
        logic       periph_clk_en;
        logic       debug_clk_en;
        logic       pin_hold;
        spg_pwr_e   pwr_core;
        spg_pwr_e   pwr_ram;
        spg_pwr_e   pwr_reg;
        spg_pwr_e   pwr_adc;
        spg_pwr_e   pwr_cmp;
        spg_pwr_e   pwr_cg;
        spg_pwr_e   pwr_rtc;
        spg_pwr_e   pwr_crystal_oscillator;
        spg_pwr_e   pwr_usb;
    } spg_state_s;

    // Low-voltage detector kept alive through stop
    function automatic logic spg_lvd_stop(input logic [7:0] mcfg);
        spg_lvd_stop = mcfg[B_LVD_EN] & mcfg[B_LVD_STOP_EN];
    endfunction

endpackage

// ===== rtl/spg_dom_sel.sv
// Per-domain power level selection from depth and captured configuration.
// Purely combinational; the caller registers every result.
`timescale 1ns/1ps
`default_nettype none
module spg_dom_sel (
    // Depth and captured configuration
    input  wire spg_pkg::spg_mode_e mode,
    input  wire logic [7:0]         mcfg,
    input  wire logic [7:0]         ccfg,
    input  wire logic [7:0]         acfg,
    // Domain controls
    output spg_pkg::spg_pwr_e       pwr_core,
    output spg_pkg::spg_pwr_e       pwr_ram,
    output spg_pkg::spg_pwr_e       pwr_reg,
    output spg_pkg::spg_pwr_e       pwr_adc,
    output spg_pkg::spg_pwr_e       pwr_cmp,
    output spg_pkg::spg_pwr_e       pwr_cg,
    output spg_pkg::spg_pwr_e       pwr_rtc,
    output spg_pkg::spg_pwr_e       pwr_crystal_oscillator,
    output spg_pkg::spg_pwr_e       pwr_usb,
    output logic                    periph_clk_en,
    output logic                    debug_clk_en,
    output logic                    pin_hold
);
    import spg_pkg::*;

    logic low_voltage_detector;
    logic ps_on;

    assign low_voltage_detector   = spg_lvd_stop(mcfg);
    assign ps_on = (acfg[B_PS_HI:B_PS_LO] != PS_OFF);

    // Level for each domain at the given depth
    always_comb begin
        pwr_core      = PWR_ON;
        pwr_ram       = PWR_ON;
        pwr_reg       = PWR_ON;
        pwr_adc       = PWR_ON;
        pwr_cmp       = PWR_ON;
        pwr_cg        = PWR_ON;
        pwr_rtc       = PWR_ON;
        pwr_crystal_oscillator      = PWR_ON;
        pwr_usb       = PWR_ON;
        periph_clk_en = 1'b1;
        debug_clk_en  = 1'b1;
        pin_hold      = 1'b0;
        case (mode)
            SPG_LIGHT: begin
                periph_clk_en = 1'b0;
                debug_clk_en  = mcfg[B_DEBUG_EN];
                pin_hold      = 1'b1;
                pwr_core      = PWR_STBY;
                pwr_ram       = PWR_STBY;
                // Full regulation kept for the detector or for debug
                pwr_reg       = (low_voltage_detector || mcfg[B_DEBUG_EN]) ? PWR_ON : PWR_STBY;
                pwr_adc  = (ccfg[B_ADC_ASYNC] && low_voltage_detector) ? PWR_ON : PWR_STBY;
                pwr_cmp  = (!ccfg[B_CMP_BANDGAP] || low_voltage_detector) ? PWR_ON : PWR_STBY;
                pwr_cg   = (ccfg[B_IREF_CLK_EN] && ccfg[B_IREF_STOP_EN]) ?
                           PWR_ON : PWR_STBY;
                pwr_rtc  = ps_on ? PWR_ON : PWR_OFF;
                pwr_crystal_oscillator = (ccfg[B_EREF_CLK_EN] && ccfg[B_EREF_STOP_EN] &&
                            (!ccfg[B_CRYSTAL_OSCILLATOR_RANGE] || low_voltage_detector)) ? PWR_ON : PWR_STBY;
                pwr_usb  = (acfg[B_USB_EN] && acfg[B_USB_PHYEN]) ?
                           PWR_ON : PWR_OFF;
            end
            SPG_DEEP: begin
                periph_clk_en = 1'b0;
                debug_clk_en  = 1'b0;
                pin_hold      = 1'b1;
                pwr_core      = PWR_OFF;
                pwr_ram       = PWR_STBY;
                pwr_reg       = PWR_OFF;
                pwr_adc       = PWR_OFF;
                pwr_cmp       = PWR_OFF;
                pwr_cg        = PWR_OFF;
                pwr_rtc       = ps_on ? PWR_ON : PWR_OFF;
                pwr_crystal_oscillator      = PWR_OFF;
                pwr_usb       = PWR_OFF;
            end
            default: begin
                pin_hold = 1'b0;
            end
        endcase
    end

endmodule // spg_dom_sel
`default_nettype wire

// ===== rtl/spg_stop_ctrl.sv
// Stop-mode power gating controller: picks the stop depth on stop entry,
// captures configuration, and drives clock and power enables per domain.
// Assumes stop_exec and wake are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module spg_stop_ctrl (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    // Processor stop control
    input  wire logic                   stop_exec,
    input  wire logic                   wake,
    // Register port
    input  wire logic [spg_pkg::AW-1:0] reg_addr,
    input  wire logic [spg_pkg::DW-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [spg_pkg::DW-1:0]      reg_rdata,
    // Clock enables and pin hold
    output logic                        periph_clk_en,
    output logic                        debug_clk_en,
    output logic                        pin_hold,
    // Domain power levels
    output spg_pkg::spg_pwr_e           pwr_core,
    output spg_pkg::spg_pwr_e           pwr_ram,
    output spg_pkg::spg_pwr_e           pwr_reg,
    output spg_pkg::spg_pwr_e           pwr_adc,
    output spg_pkg::spg_pwr_e           pwr_cmp,
    output spg_pkg::spg_pwr_e           pwr_cg,
    output spg_pkg::spg_pwr_e           pwr_rtc,
    output spg_pkg::spg_pwr_e           pwr_crystal_oscillator,
    output spg_pkg::spg_pwr_e           pwr_usb
);
    import spg_pkg::*;

    spg_state_s state_q;
    spg_state_s state_d;
    logic       stop_take;
    logic       go_deep;
    logic [7:0] status;
    spg_pwr_e   sel_core;
    spg_pwr_e   sel_ram;
    spg_pwr_e   sel_reg;
    spg_pwr_e   sel_adc;
    spg_pwr_e   sel_cmp;
    spg_pwr_e   sel_cg;
    spg_pwr_e   sel_rtc;
    spg_pwr_e   sel_crystal_oscillator;
    spg_pwr_e   sel_usb;
    logic       sel_pclk;
    logic       sel_dclk;
    logic       sel_hold;
    spg_mode_e  mode_nx;
    logic [7:0] snap_mode_nx;
    logic [7:0] snap_clk_nx;
    logic [7:0] snap_aux_nx;

    // Depth held after this edge: entry from run, wake from either stop
    function automatic spg_mode_e next_depth(input spg_mode_e cur, input logic take,
                                             input logic deep, input logic wk);
        case (cur)
            SPG_RUN: begin
                if (take) begin
                    next_depth = deep ? SPG_DEEP : SPG_LIGHT;
                end else begin
                    next_depth = SPG_RUN;
                end
            end
            SPG_LIGHT, SPG_DEEP: begin
                next_depth = wk ? SPG_RUN : cur;
            end
            default: begin
                next_depth = SPG_RUN;
            end
        endcase
    endfunction

    // Stop accepted only from run with stops allowed
    assign stop_take = stop_exec && (state_q.mode == SPG_RUN) &&
                       state_q.mode_cfg[B_STOP_EN];
    // Deep depth refused while detector or debug must stay alive
    assign go_deep   = state_q.mode_cfg[B_DEEP_SEL] &&
                       !spg_lvd_stop(state_q.mode_cfg) &&
                       !state_q.mode_cfg[B_DEBUG_EN];

    // Depth and snapshot for the coming cycle, kept apart from the state copy
    // so that the selector does not read back the record it feeds
    assign mode_nx      = next_depth(state_q.mode, stop_take, go_deep, wake);
    assign snap_mode_nx = stop_take ? state_q.mode_cfg : state_q.snap_mode;
    assign snap_clk_nx  = stop_take ? state_q.clk_cfg  : state_q.snap_clk;
    assign snap_aux_nx  = stop_take ? state_q.aux_cfg  : state_q.snap_aux;

    // Status word
    always_comb begin
        status                           = RST_DATA;
        status[B_ST_MODE_HI:B_ST_MODE_LO] = state_q.mode;
        status[B_ST_REG_ON]              = (state_q.pwr_reg == PWR_ON);
        status[B_ST_DBG_CLK]             = state_q.debug_clk_en;
    end

    // Domain levels for the depth about to be held
    spg_dom_sel u_sel (
        .mode          (mode_nx),
        .mcfg          (snap_mode_nx),
        .ccfg          (snap_clk_nx),
        .acfg          (snap_aux_nx),
        .pwr_core      (sel_core),
        .pwr_ram       (sel_ram),
        .pwr_reg       (sel_reg),
        .pwr_adc       (sel_adc),
        .pwr_cmp       (sel_cmp),
        .pwr_cg        (sel_cg),
        .pwr_rtc       (sel_rtc),
        .pwr_crystal_oscillator      (sel_crystal_oscillator),
        .pwr_usb       (sel_usb),
        .periph_clk_en (sel_pclk),
        .debug_clk_en  (sel_dclk),
        .pin_hold      (sel_hold)
    );

    // Next state: depth, registers, snapshot, read data, outputs
    always_comb begin
        state_d       = state_q;
        state_d.rdata = RST_DATA;
        state_d.mode      = mode_nx;
        state_d.snap_mode = snap_mode_nx;
        state_d.snap_clk  = snap_clk_nx;
        state_d.snap_aux  = snap_aux_nx;
        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_MODE_CFG: state_d.mode_cfg = reg_wdata;
                ADDR_CLK_CFG:  state_d.clk_cfg  = reg_wdata;
                ADDR_AUX_CFG:  state_d.aux_cfg  = reg_wdata;
                default:       state_d.mode_cfg = state_q.mode_cfg;
            endcase
        end
        // Register reads, unmapped reads as zero
        if (reg_rd) begin
            case (reg_addr)
                ADDR_MODE_CFG: state_d.rdata = state_q.mode_cfg;
                ADDR_CLK_CFG:  state_d.rdata = state_q.clk_cfg;
                ADDR_AUX_CFG:  state_d.rdata = state_q.aux_cfg;
                ADDR_STATUS:   state_d.rdata = status;
                default:       state_d.rdata = RST_DATA;
            endcase
        end
        state_d.periph_clk_en = sel_pclk;
        state_d.debug_clk_en  = sel_dclk;
        state_d.pin_hold      = sel_hold;
        state_d.pwr_core      = sel_core;
        state_d.pwr_ram       = sel_ram;
        state_d.pwr_reg       = sel_reg;
        state_d.pwr_adc       = sel_adc;
        state_d.pwr_cmp       = sel_cmp;
        state_d.pwr_cg        = sel_cg;
        state_d.pwr_rtc       = sel_rtc;
        state_d.pwr_crystal_oscillator      = sel_crystal_oscillator;
        state_d.pwr_usb       = sel_usb;
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q               <= '0;
            state_q.mode          <= SPG_RUN;
            state_q.mode_cfg      <= RST_CFG;
            state_q.clk_cfg       <= RST_CFG;
            state_q.aux_cfg       <= RST_CFG;
            state_q.periph_clk_en <= 1'b1;
            state_q.debug_clk_en  <= 1'b1;
            state_q.pwr_core      <= PWR_ON;
            state_q.pwr_ram       <= PWR_ON;
            state_q.pwr_reg       <= PWR_ON;
            state_q.pwr_adc       <= PWR_ON;
            state_q.pwr_cmp       <= PWR_ON;
            state_q.pwr_cg        <= PWR_ON;
            state_q.pwr_rtc       <= PWR_ON;
            state_q.pwr_crystal_oscillator      <= PWR_ON;
            state_q.pwr_usb       <= PWR_ON;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata     = state_q.rdata;
    assign periph_clk_en = state_q.periph_clk_en;
    assign debug_clk_en  = state_q.debug_clk_en;
    assign pin_hold      = state_q.pin_hold;
    assign pwr_core      = state_q.pwr_core;
    assign pwr_ram       = state_q.pwr_ram;
    assign pwr_reg       = state_q.pwr_reg;
    assign pwr_adc       = state_q.pwr_adc;
    assign pwr_cmp       = state_q.pwr_cmp;
    assign pwr_cg        = state_q.pwr_cg;
    assign pwr_rtc       = state_q.pwr_rtc;
    assign pwr_crystal_oscillator      = state_q.pwr_crystal_oscillator;
    assign pwr_usb       = state_q.pwr_usb;

    // Checks on the selection
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    logic lvd_snap;
    assign lvd_snap = spg_lvd_stop(state_q.snap_mode);

    sequence take_deep_s;
        stop_take && state_q.mode_cfg[B_DEEP_SEL];
    endsequence

    clk_gate_a: assert property (stop_take |=> !periph_clk_en ##1
        (!periph_clk_en || $past(wake)))
        else $error("peripheral clocks not halted in stop");
    debug_clk_a: assert property (
        stop_take && state_q.mode_cfg[B_DEBUG_EN] |=> debug_clk_en && !periph_clk_en)
        else $error("debug clock not kept in stop");
    adc_light_a: assert property (state_q.mode == SPG_LIGHT |->
        ((pwr_adc == PWR_ON) == (state_q.snap_clk[B_ADC_ASYNC] && lvd_snap)))
        else $error("converter level wrong in light stop");
    cmp_bandgap_a: assert property (state_q.mode == SPG_LIGHT &&
        state_q.snap_clk[B_CMP_BANDGAP] |-> ((pwr_cmp == PWR_ON) == lvd_snap))
        else $error("comparator level wrong in light stop");
    clkgen_ref_a: assert property (state_q.mode == SPG_LIGHT |-> ((pwr_cg == PWR_ON) ==
        (state_q.snap_clk[B_IREF_CLK_EN] && state_q.snap_clk[B_IREF_STOP_EN])))
        else $error("clock generator level wrong in light stop");
    rtc_keep_a: assert property (stop_take |=> ((pwr_rtc == PWR_ON) ==
        ($past(state_q.aux_cfg[B_PS_HI:B_PS_LO]) != PS_OFF)))
        else $error("counter level does not follow prescale at entry");
    crystal_oscillator_ext_a: assert property (state_q.mode == SPG_LIGHT && !(state_q.snap_clk[B_EREF_CLK_EN]
        && state_q.snap_clk[B_EREF_STOP_EN]) |-> pwr_crystal_oscillator == PWR_STBY)
        else $error("oscillator kept without external enables");
    crystal_oscillator_range_a: assert property (state_q.mode == SPG_LIGHT &&
        state_q.snap_clk[B_CRYSTAL_OSCILLATOR_RANGE] && !lvd_snap |-> pwr_crystal_oscillator != PWR_ON)
        else $error("high range oscillator kept without detector");
    usb_light_a: assert property (state_q.mode == SPG_LIGHT |-> ((pwr_usb == PWR_ON) ==
        (state_q.snap_aux[B_USB_EN] && state_q.snap_aux[B_USB_PHYEN])))
        else $error("USB level wrong in light stop");
    deep_domains_a: assert property (state_q.mode == SPG_DEEP |-> pwr_core == PWR_OFF &&
        pwr_reg == PWR_OFF && pwr_ram == PWR_STBY && pin_hold)
        else $error("deep stop domain levels wrong");
    lvd_redirect_a: assert property (take_deep_s ##0 spg_lvd_stop(state_q.mode_cfg) |=>
        state_q.mode == SPG_LIGHT && pwr_reg == PWR_ON)
        else $error("deep stop not redirected with detector on");
    dbg_redirect_a: assert property (take_deep_s ##0 state_q.mode_cfg[B_DEBUG_EN] |=>
        state_q.mode == SPG_LIGHT && debug_clk_en && pwr_reg == PWR_ON)
        else $error("deep stop not redirected with debug on");

endmodule // spg_stop_ctrl
`default_nettype wire

// ===== tb/stop_mode_power_gating_test.sv
// Self-checking bench for the stop-mode power gating controller.
// Assumes the controller of rtl/spg_stop_ctrl.sv and its package, one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module stop_mode_power_gating_test;
    import spg_pkg::*;

    logic            core_clk;
    logic            rst_b;
    logic            stop_exec;
    logic            wake;
    logic [AW-1:0]   reg_addr;
    logic [DW-1:0]   reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [DW-1:0]   reg_rdata;
    logic            periph_clk_en;
    logic            debug_clk_en;
    logic            pin_hold;
    spg_pwr_e        pwr_core, pwr_ram, pwr_reg, pwr_adc, pwr_cmp;
    spg_pwr_e        pwr_cg, pwr_rtc, pwr_crystal_oscillator, pwr_usb;
    logic [20:0]     obs;
    logic [7:0]      got;
    logic [23:0]     corner [6];
    int              error_cnt;
    int              n_tests;

    // All controlled outputs side by side
    assign obs = {periph_clk_en, debug_clk_en, pin_hold, pwr_core, pwr_ram, pwr_reg,
                  pwr_adc, pwr_cmp, pwr_cg, pwr_rtc, pwr_crystal_oscillator, pwr_usb};

    spg_stop_ctrl spg_stop_ctrl_i (
        .core_clk(core_clk), .rst_b(rst_b), .stop_exec(stop_exec), .wake(wake),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .periph_clk_en(periph_clk_en),
        .debug_clk_en(debug_clk_en), .pin_hold(pin_hold), .pwr_core(pwr_core),
        .pwr_ram(pwr_ram), .pwr_reg(pwr_reg), .pwr_adc(pwr_adc), .pwr_cmp(pwr_cmp),
        .pwr_cg(pwr_cg), .pwr_rtc(pwr_rtc), .pwr_crystal_oscillator(pwr_crystal_oscillator), .pwr_usb(pwr_usb)
    );

    // Clock generator, 5 ns period
    always #2.5 core_clk = ~core_clk;

    // Depth picked from the mode configuration: 1 light, 2 deep
    function automatic logic [1:0] exp_depth(input logic [7:0] m);
        if (m[B_DEEP_SEL] && !(m[B_LVD_EN] && m[B_LVD_STOP_EN]) && !m[B_DEBUG_EN])
            return 2'h2;
        return 2'h1;
    endfunction

    // Expected outputs; levels 0 off, 1 standby, 2 on
    function automatic logic [20:0] exp_out(input logic [1:0] d,
                                            input logic [7:0] m, c, a);
        logic       lv;
        logic [1:0] rtc;
        lv  = m[B_LVD_EN] & m[B_LVD_STOP_EN];
        rtc = (a[B_PS_HI:B_PS_LO] != PS_OFF) ? 2'h2 : 2'h0;
        if (d == 2'h0)
            return {3'b110, {9{2'h2}}};
        if (d == 2'h2)
            return {3'b001, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, rtc, 2'h0, 2'h0};
        return {1'b0, m[B_DEBUG_EN], 1'b1, 2'h1, 2'h1,
                (lv | m[B_DEBUG_EN]) ? 2'h2 : 2'h1,
                (c[B_ADC_ASYNC] & lv) ? 2'h2 : 2'h1,
                (!c[B_CMP_BANDGAP] | lv) ? 2'h2 : 2'h1,
                (c[B_IREF_CLK_EN] & c[B_IREF_STOP_EN]) ? 2'h2 : 2'h1,
                rtc,
                (c[B_EREF_CLK_EN] & c[B_EREF_STOP_EN] & (!c[B_CRYSTAL_OSCILLATOR_RANGE] | lv)) ?
                    2'h2 : 2'h1,
                (a[B_USB_EN] & a[B_USB_PHYEN]) ? 2'h2 : 2'h0};
    endfunction

    // Expected status word
    function automatic logic [7:0] exp_status(input logic [1:0] d, input logic [7:0] m);
        logic [20:0] o;
        o = exp_out(d, m, 8'h00, 8'h00);
        return {4'h0, o[19], o[13:12] == 2'h2, d};
    endfunction

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Register write, one strobe cycle then a quiet one
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        @(posedge core_clk);
    endtask

    // Register read; data stand one cycle and then fall back to zero
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        @(posedge core_clk);
        #1 chk("rdata_idle", 24'h0, {16'h0, reg_rdata});
        @(posedge core_clk);
    endtask

    // One-cycle pulse on stop entry or wake, then output comparison
    task automatic pulse(input bit is_wake, input logic [1:0] d, input logic [7:0] m, c, a);
        if (is_wake)
            wake <= 1'b1;
        else
            stop_exec <= 1'b1;
        @(posedge core_clk);
        wake      <= 1'b0;
        stop_exec <= 1'b0;
        #1 chk("outputs", {3'h0, exp_out(d, m, c, a)}, {3'h0, obs});
        @(posedge core_clk);
    endtask

    // Full stop cycle: configure, enter, rewrite the live configuration and retry stop, wake
    task automatic stop_cycle(input logic [7:0] m, c, a);
        logic [1:0] d;
        d = exp_depth(m);
        wr(ADDR_MODE_CFG, m);
        wr(ADDR_CLK_CFG, c);
        wr(ADDR_AUX_CFG, a);
        rd(ADDR_CLK_CFG, got);
        chk("clk_cfg", {16'h0, c}, {16'h0, got});
        pulse(1'b0, d, m, c, a);
        rd(ADDR_STATUS, got);
        chk("status", {16'h0, exp_status(d, m)}, {16'h0, got});
        wr(ADDR_CLK_CFG, ~c & 8'h7F);
        wr(ADDR_AUX_CFG, ~a & 8'h3F);
        pulse(1'b0, d, m, c, a);
        pulse(1'b1, 2'h0, m, c, a);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Guard against a hung run
    initial begin
        repeat (90000) @(posedge core_clk);
        error_cnt++;
        $display("[ERR] run_time expected end seen limit");
        finish_test();
    end

    // Main sequence
    initial begin
        core_clk  = 1'b0;
        rst_b     = 1'b0;
        stop_exec = 1'b0;
        wake      = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        error_cnt = 0;
        n_tests   = 0;
        corner    = '{24'h140000, 24'h147F3F, 24'h177F3F, 24'h1C5C10, 24'h102321, 24'h132C0F};
        void'($urandom(16));
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        // Reset levels and the whole address space
        #1 chk("outputs", {3'h0, exp_out(2'h0, 8'h0, 8'h0, 8'h0)}, {3'h0, obs});
        @(posedge core_clk);
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), got);
            chk("read", (i == 3) ? 24'h0C : 24'h0, {16'h0, got});
        end
        $display("test reset done");
        // Stop refused while disabled, wake ignored in run, read-only places
        wr(ADDR_MODE_CFG, 8'h0F);
        pulse(1'b0, 2'h0, 8'h0, 8'h0, 8'h0);
        pulse(1'b1, 2'h0, 8'h0, 8'h0, 8'h0);
        wr(ADDR_STATUS, 8'hFF);
        wr(4'h9, 8'hFF);
        rd(ADDR_STATUS, got);
        chk("status", 24'h0C, {16'h0, got});
        rd(4'h9, got);
        chk("unmapped", 24'h0, {16'h0, got});
        $display("test refused done");
        // Hand-picked depth and domain corners
        foreach (corner[k])
            stop_cycle(corner[k][23:16], corner[k][15:8], corner[k][7:0]);
        $display("test corners done");
        // Random configurations
        for (int k = 0; k < 150; k++)
            stop_cycle(8'h10 | 8'($urandom & 32'h0F), 8'($urandom & 32'h7F),
                       8'($urandom & 32'h3F));
        $display("test random done");
        finish_test();
    end

endmodule // stop_mode_power_gating_test
`default_nettype wire
